//--- logic/hbw_pkg.sv
// constants shared by the host bus wait port
package hbw_pkg;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int DATA_W          = 8;
    localparam int ADDR_W          = 16;
    localparam int STROBES         = 2;
    localparam int STB_RD          = 0;
    localparam int STB_WR          = 1;
    // longest stall: 4 clock periods plus 2 ns, rounded down
    localparam int WAIT_MAX_TS     = 4;
    localparam int WAIT_MAX_XNS    = 2;
    localparam int WAIT_MAX_NS     = WAIT_MAX_TS * CLK_PERIOD_NS + WAIT_MAX_XNS;
    localparam int WAIT_MAX_CYC    = WAIT_MAX_NS / CLK_PERIOD_NS;
    // data after stall release: 1 period plus 7 ns, rounded down
    localparam int DATA_WAIT_TS    = 1;
    localparam int DATA_WAIT_XNS   = 7;
    localparam int DATA_WAIT_NS    = DATA_WAIT_TS * CLK_PERIOD_NS + DATA_WAIT_XNS;
    localparam int DATA_WAIT_CYC   = DATA_WAIT_NS / CLK_PERIOD_NS;
    // data after read fall without stall: 4 periods plus 20 ns, rounded down
    localparam int RD_NOWAIT_TS    = 4;
    localparam int RD_NOWAIT_XNS   = 20;
    localparam int RD_NOWAIT_NS    = RD_NOWAIT_TS * CLK_PERIOD_NS + RD_NOWAIT_XNS;
    localparam int RD_NOWAIT_CYC   = RD_NOWAIT_NS / CLK_PERIOD_NS;
    // host side minimum strobe width in clock periods
    localparam int STROBE_MIN_CYC  = 5;
    localparam int RD_LAT_DEF      = 1;
    localparam int CNT_W           = 3;
    localparam logic [DATA_W-1:0] BUS_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_STALL = 2'b01,
        ST_HOLD  = 2'b10
    } hbw_state_type;
endpackage

//--- logic/hbw_port.sv
// host parallel bus port with optional wait handshake
`timescale 1ns/10ps
`default_nettype none
module hbw_port #(
    parameter int unsigned RD_LAT = hbw_pkg::RD_LAT_DEF
) (
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    input  wire logic                       cs_n,
    input  wire logic                       rd_n,
    input  wire logic                       wr_n,
    input  wire logic [hbw_pkg::ADDR_W-1:0] host_addr,
    input  wire logic [hbw_pkg::DATA_W-1:0] host_bus_in,
    output logic      [hbw_pkg::DATA_W-1:0] host_bus_out,
    output logic                            host_bus_oe_n,
    output logic                            wait_n_out,
    output logic                            wait_oe_n,
    input  wire logic                       wait_enable,
    output logic      [hbw_pkg::ADDR_W-1:0] core_addr,
    output logic                            core_rd,
    input  wire logic [hbw_pkg::DATA_W-1:0] core_rdata,
    output logic                            core_wr,
    output logic      [hbw_pkg::DATA_W-1:0] core_wdata
);
    import hbw_pkg::*;

    // stall length of a read, must keep RD_LAT + 1 within WAIT_MAX_CYC
    localparam logic [CNT_W-1:0] RD_TARGET = CNT_W'(RD_LAT);
    localparam int RD_WIN = RD_NOWAIT_CYC;
    localparam int DW_WIN = DATA_WAIT_CYC;

    logic [STROBES-1:0] fall;
    logic [STROBES-1:0] rise;
    logic [DATA_W-1:0]  bus_last;

    hbw_strobe_edge u_edge (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .strobe_n    ({wr_n, rd_n}),
        .host_bus_in (host_bus_in),
        .fall        (fall),
        .rise        (rise),
        .bus_last    (bus_last)
    );

    hbw_state_type     state_reg;
    hbw_state_type     state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic              is_rd_reg;
    logic              is_rd_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic              wait_n_reg;
    logic              wait_n_next;
    logic              wait_oe_n_reg;
    logic              wait_oe_n_next;
    logic [DATA_W-1:0] bus_out_reg;
    logic [DATA_W-1:0] bus_out_next;
    logic              bus_oe_n_reg;
    logic              bus_oe_n_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic              core_rd_reg;
    logic              core_rd_next;
    logic              core_wr_reg;
    logic              core_wr_next;
    logic              active_rise;
    logic [CNT_W-1:0]  target;

    assign active_rise = is_rd_reg ? rise[STB_RD] : rise[STB_WR];
    // writes stall one cycle, just long enough to show the handshake
    assign target      = is_rd_reg ? RD_TARGET : '0;

    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        is_rd_next     = is_rd_reg;
        rvalid_next    = rvalid_reg;
        wait_n_next    = wait_n_reg;
        wait_oe_n_next = wait_oe_n_reg;
        bus_out_next   = bus_out_reg;
        bus_oe_n_next  = bus_oe_n_reg;
        addr_next      = addr_reg;
        wdata_next     = wdata_reg;
        core_rd_next   = 1'b0;
        core_wr_next   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (!cs_n && (fall[STB_RD] || fall[STB_WR])) begin
                    state_next   = ST_STALL;
                    cnt_next     = '0;
                    is_rd_next   = fall[STB_RD];
                    rvalid_next  = 1'b0;
                    addr_next    = host_addr;
                    core_rd_next = fall[STB_RD];
                    if (wait_enable) begin
                        wait_n_next    = 1'b0;
                        wait_oe_n_next = 1'b0;
                    end
                    if (fall[STB_RD]) begin
                        bus_oe_n_next = 1'b0;
                    end
                end
            end
            ST_STALL: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg == target) begin
                    if (is_rd_reg) begin
                        bus_out_next = core_rdata;
                        rvalid_next  = 1'b1;
                    end
                    wait_n_next = 1'b1;
                    state_next  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_next = ST_HOLD;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (state_reg != ST_IDLE && active_rise) begin
            state_next     = ST_IDLE;
            wait_n_next    = 1'b1;
            wait_oe_n_next = 1'b1;
            bus_oe_n_next  = 1'b1;
            if (!is_rd_reg) begin
                core_wr_next = 1'b1;
                wdata_next   = bus_last;
            end
        end
        // deselect mid-access aborts, a pending write is dropped
        if (state_reg != ST_IDLE && cs_n) begin
            state_next     = ST_IDLE;
            wait_n_next    = 1'b1;
            wait_oe_n_next = 1'b1;
            bus_oe_n_next  = 1'b1;
            core_wr_next   = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= '0;
            is_rd_reg     <= 1'b0;
            rvalid_reg    <= 1'b0;
            wait_n_reg    <= 1'b1;
            wait_oe_n_reg <= 1'b1;
            bus_out_reg   <= BUS_RESET;
            bus_oe_n_reg  <= 1'b1;
            addr_reg      <= ADDR_RESET;
            wdata_reg     <= BUS_RESET;
            core_rd_reg   <= 1'b0;
            core_wr_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            is_rd_reg     <= is_rd_next;
            rvalid_reg    <= rvalid_next;
            wait_n_reg    <= wait_n_next;
            wait_oe_n_reg <= wait_oe_n_next;
            bus_out_reg   <= bus_out_next;
            bus_oe_n_reg  <= bus_oe_n_next;
            addr_reg      <= addr_next;
            wdata_reg     <= wdata_next;
            core_rd_reg   <= core_rd_next;
            core_wr_reg   <= core_wr_next;
        end
    end

    assign host_bus_out  = bus_out_reg;
    assign host_bus_oe_n = bus_oe_n_reg;
    assign wait_n_out    = wait_n_reg;
    assign wait_oe_n     = wait_oe_n_reg;
    assign core_addr     = addr_reg;
    assign core_rd       = core_rd_reg;
    assign core_wr       = core_wr_reg;
    assign core_wdata    = wdata_reg;

    // helper: length of the current stall
    logic [CNT_W:0] stall_len_reg;
    logic [CNT_W:0] stall_len_next;
    always_comb begin
        stall_len_next = '0;
        if (!wait_oe_n_reg && !wait_n_reg) begin
            stall_len_next = stall_len_reg + (CNT_W+1)'(1);
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stall_len_reg <= '0;
        end else begin
            stall_len_reg <= stall_len_next;
        end
    end

    sequence s_sel_start;
        state_reg == ST_IDLE && !cs_n && (fall[STB_RD] || fall[STB_WR]);
    endsequence

    sequence s_read_start;
        state_reg == ST_IDLE && !cs_n && fall[STB_RD];
    endsequence

    sequence s_stalled;
        !wait_oe_n_reg && !wait_n_reg;
    endsequence

    AST_WAIT_ON_FALL: assert property (@(posedge mclk) disable iff (!reset_n)
        s_sel_start and wait_enable |=> s_stalled)
        else $error("wait not driven low after strobe fall");

    AST_RD_REQUEST: assert property (@(posedge mclk) disable iff (!reset_n)
        s_read_start |=> core_rd_reg ##1 !core_rd_reg)
        else $error("core read request not a single pulse");

    AST_RELEASE_ON_RISE: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg != ST_IDLE && active_rise |=> wait_oe_n_reg && bus_oe_n_reg)
        else $error("wait or bus still driven after strobe rise");

    AST_WAIT_BOUND: assert property (@(posedge mclk) disable iff (!reset_n)
        stall_len_reg <= (CNT_W+1)'(WAIT_MAX_CYC))
        else $error("wait held low too long");

    AST_DATA_AT_WAIT_RISE: assert property (@(posedge mclk) disable iff (!reset_n)
        s_stalled ##1 (!wait_oe_n_reg && wait_n_reg && is_rd_reg)
        |-> ##[0:DW_WIN] (host_bus_out == $past(core_rdata) && rvalid_reg))
        else $error("read data not valid at wait release");

    AST_DATA_NO_WAIT: assert property (@(posedge mclk) disable iff (!reset_n)
        s_read_start and !wait_enable |-> ##[1:RD_WIN] (rvalid_reg || state_reg == ST_IDLE))
        else $error("read data late without wait");

    AST_DESELECT_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
        cs_n |=> wait_oe_n_reg && bus_oe_n_reg && !core_wr_reg)
        else $error("port active while deselected");

    AST_WRITE_DATA: assert property (@(posedge mclk) disable iff (!reset_n)
        state_reg != ST_IDLE && !is_rd_reg && rise[STB_WR] && !cs_n
        |=> core_wr_reg && core_wdata == $past(bus_last))
        else $error("write not committed with bus value");
endmodule
`default_nettype wire

//--- logic/hbw_strobe_edge.sv
// edge detection of the read and write strobes
`timescale 1ns/10ps
`default_nettype none
module hbw_strobe_edge (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic [hbw_pkg::STROBES-1:0] strobe_n,
    input  wire logic [hbw_pkg::DATA_W-1:0]  host_bus_in,
    output logic      [hbw_pkg::STROBES-1:0] fall,
    output logic      [hbw_pkg::STROBES-1:0] rise,
    output logic      [hbw_pkg::DATA_W-1:0]  bus_last
);
    import hbw_pkg::*;

    logic [STROBES-1:0] prev_reg;
    logic [STROBES-1:0] prev_next;
    logic [DATA_W-1:0]  bus_reg;
    logic [DATA_W-1:0]  bus_next;

    genvar i;
    generate
        for (i = 0; i < STROBES; i = i + 1) begin : g_stb
            assign fall[i] = prev_reg[i] & ~strobe_n[i];
            assign rise[i] = ~prev_reg[i] & strobe_n[i];
        end
    endgenerate

    // bus of the cycle before the rise, the edge itself may lose hold
    assign bus_last = bus_reg;

    always_comb begin
        prev_next = strobe_n;
        bus_next  = host_bus_in;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev_reg <= '1;
            bus_reg  <= BUS_RESET;
        end else begin
            prev_reg <= prev_next;
            bus_reg  <= bus_next;
        end
    end
endmodule
`default_nettype wire

//--- tb/hbw_host_model.sv
// host processor model driving the parallel bus
`timescale 1ns/10ps
`default_nettype none
module hbw_host_model (
    input  wire logic                       mclk,
    input  wire logic                       wait_pin,
    input  wire logic [hbw_pkg::DATA_W-1:0] bus_pin,
    output logic                            cs_n,
    output logic                            rd_n,
    output logic                            wr_n,
    output logic      [hbw_pkg::ADDR_W-1:0] addr,
    output logic      [hbw_pkg::DATA_W-1:0] dat,
    output logic                            dat_oe_n
);
    import hbw_pkg::*;
    logic last_wr = 1'b0;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = ADDR_RESET;
        dat = 8'h3C;
        dat_oe_n = 1'b1;
    end
    // mode 0 normal, 1 deselect mid-access, 2 never selected
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd, input int mode,
                          input logic use_wait, output logic [DATA_W-1:0] rv);
        int n;
        int seen;
        repeat (last_wr ? (wr ? 3 : 6) : 1) @(negedge mclk);
        cs_n = (mode == 2);
        addr = a;
        dat = wd;
        dat_oe_n = !wr;
        rd_n = wr;
        wr_n = !wr;
        n = 0;
        seen = -1;
        rv = 8'h00;
        while (n < 30) begin
            @(negedge mclk);
            n++;
            if (mode == 1 && n == 2) cs_n = 1'b1;
            if (use_wait && seen < 0 && wait_pin) seen = n;
            // data must be valid one period after stall release, or 52 ns after fall
            if ((use_wait && n == seen + 1) || (!use_wait && n == 6)) rv = bus_pin;
            if (n >= 6 && (!use_wait || (seen >= 0 && n > seen))) break;
        end
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(negedge mclk);
        dat_oe_n = 1'b1;
        dat = ~dat;
        cs_n = 1'b1;
        last_wr = wr;
    endtask
endmodule
`default_nettype wire

//--- tb/test_hbw_port.sv
// self-checking bench of the host bus wait port
`timescale 1ns/10ps
`default_nettype none
module test_hbw_port;
    import hbw_pkg::*;
    logic              mclk;
    logic              reset_n;
    logic              wait_enable;
    logic              cs_n, rd_n, wr_n, hoe_n, wait_pin;
    logic              host_bus_oe_n, wait_n_out, wait_oe_n, core_rd, core_wr;
    logic [ADDR_W-1:0] host_addr, core_addr, wr_addr;
    logic [DATA_W-1:0] host_bus_in, host_bus_out, core_wdata, hdat, rv, wr_data;
    logic [DATA_W-1:0] core_rdata = 8'h00;
    int                n_errors = 0;
    int                checks_done = 0;
    int                stall, stall_max, n_wr, n_rd, n_wdrv, n_bdrv;

    // wait has a pull-up; an undriven data bus shows the inverted last value
    assign wait_pin = wait_oe_n ? 1'b1 : wait_n_out;
    assign host_bus_in = !hoe_n ? hdat : (!host_bus_oe_n ? host_bus_out : ~hdat);

    hbw_port #(.RD_LAT(RD_LAT_DEF)) u_dut (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .host_addr(host_addr), .host_bus_in(host_bus_in),
        .host_bus_out(host_bus_out), .host_bus_oe_n(host_bus_oe_n),
        .wait_n_out(wait_n_out), .wait_oe_n(wait_oe_n), .wait_enable(wait_enable),
        .core_addr(core_addr), .core_rd(core_rd), .core_rdata(core_rdata),
        .core_wr(core_wr), .core_wdata(core_wdata));
    hbw_host_model u_host (.mclk(mclk), .wait_pin(wait_pin), .bus_pin(host_bus_in),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(host_addr), .dat(hdat),
        .dat_oe_n(hoe_n));

    always @(negedge mclk) core_rdata <= core_addr[7:0] ^ 8'h5A;
    always @(posedge mclk) begin
        stall = (!wait_oe_n && !wait_n_out) ? stall + 1 : 0;
        if (stall > stall_max) stall_max = stall;
        if (core_wr) begin
            n_wr++;
            wr_data = core_wdata;
            wr_addr = core_addr;
        end
        if (core_rd) n_rd++;
        if (!wait_oe_n) n_wdrv++;
        if (!host_bus_oe_n) n_bdrv++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask
    task automatic clr;
        {stall, stall_max, n_wr, n_rd, n_wdrv, n_bdrv} = '0;
    endtask
    task automatic released;
        @(negedge mclk);
        check(wait_oe_n, 1'b1, "wait not released");
        check(host_bus_oe_n, 1'b1, "bus not released");
    endtask
    task automatic t_read(input logic [ADDR_W-1:0] a, input logic w);
        wait_enable = w;
        clr;
        u_host.access(1'b0, a, 8'h00, 0, w, rv);
        check(rv, a[7:0] ^ 8'h5A, "read data");
        check(n_rd, 1, "core read count");
        check(stall_max > 0, w, "stall presence");
        check(stall_max <= WAIT_MAX_CYC, 1'b1, "stall too long");
        check(n_wdrv > 0, w, "wait drive");
        released;
    endtask
    task automatic t_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wait_enable = 1'b1;
        clr;
        u_host.access(1'b1, a, d, 0, 1'b1, rv);
        released;
        check(n_wr, 1, "core write count");
        check(wr_data, d, "write data");
        check(wr_addr, a, "write address");
        check(stall_max > 0, 1'b1, "write stall");
        check(stall_max <= WAIT_MAX_CYC, 1'b1, "write stall long");
    endtask
    // strobes while never selected, then a write dropped by deselect
    task automatic t_unselected;
        wait_enable = 1'b1;
        clr;
        u_host.access(1'b0, 16'h0011, 8'h00, 2, 1'b1, rv);
        u_host.access(1'b1, 16'h0022, 8'h77, 2, 1'b1, rv);
        check(n_wdrv + n_bdrv, 0, "driven while unselected");
        check(n_rd + n_wr, 0, "core access while unselected");
        u_host.access(1'b1, 16'h2222, 8'h99, 1, 1'b1, rv);
        released;
        check(n_wr, 0, "aborted write committed");
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        #(3000 * 8);
        n_errors++;
        print_verdict;
    end
    initial begin
        reset_n = 1'b0;
        wait_enable = 1'b1;
        repeat (3) @(negedge mclk);
        check(wait_oe_n, 1'b1, "reset wait enable");
        check(host_bus_oe_n, 1'b1, "reset bus enable");
        check({core_rd, core_wr, wait_n_out}, 3'b001, "reset strobes");
        check(core_addr, ADDR_RESET, "reset address");
        check(host_bus_out, BUS_RESET, "reset read data");
        check(core_wdata, BUS_RESET, "reset write data");
        reset_n = 1'b1;
        t_read(16'h1234, 1'b1);
        t_write(16'hBEEF, 8'hC3);
        t_read(16'h00A7, 1'b1);
        t_read(16'hFF00, 1'b0);
        t_write(16'h0001, 8'hFF);
        t_write(16'h8000, 8'h00);
        t_read(16'h7E81, 1'b0);
        t_unselected;
        t_read(16'h55AA, 1'b1);
        print_verdict;
    end
endmodule
`default_nettype wire
